/* File: core/pwd_pkg.sv */
// package for the pcm word decode control block
// assumes one 25 MHz system clock; all strobes arrive as pins and are synchronised in the core
package pwd_pkg;
  // ----------------------------------------
  // word layout
  // ----------------------------------------
  localparam int WORD_W = 6;
  localparam int MSD_POS = 5;
  localparam int NMSD_POS = 4;
  localparam int LSD_POS = 0;
  localparam logic [5:0] WORD_RST = 6'h00;
  // ----------------------------------------
  // level-control and path outputs
  // ----------------------------------------
  typedef struct packed {
    logic msd;
    logic msd_n;
    logic nmsd;
    logic nmsd_n;
  } pwd_level_t;
  typedef struct packed {
    logic atten_sel;
    logic direct_sel;
  } pwd_path_t;
  localparam logic [3:0] LEVEL_RST = 4'h5;
  localparam logic [1:0] PATH_RST = 2'h1;
  localparam int SYNC_STAGES = 2;
endpackage : pwd_pkg

/* File: core/pwd_core.sv */
// pcm word decode control: serial gather, parallel hold, address blank, squelch, path select
// assumes all pin inputs are asynchronous to clk and pulse widths span at least two clk periods
`timescale 1ns/1ps

module pwd_core
  import pwd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link pins from receive timing
  input wire logic pcm_in,
  input wire logic dec_clk_in,
  input wire logic word_readout_strobe,
  input wire logic addr_inh1,
  input wire logic addr_inh2,
  input wire logic in_frame,
  // outputs to ladder and gain switch
  output logic [WORD_W-1:0] held_word,
  output pwd_level_t level_ctl,
  output pwd_path_t path_sel,
  output logic modem_timing
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // the lsd clear path and the two-digit path decode are written for this layout only
  if (WORD_W != 6 || MSD_POS != WORD_W - 1 || NMSD_POS != WORD_W - 2 || LSD_POS != 0) begin : g_layout_chk
    $error("pwd_core needs a six-bit word with the msd on top");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam int NIN = 6;
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] meta_r;
  logic [NIN-1:0] sync_r;
  logic [NIN-1:0] meta_nxt;
  logic [NIN-1:0] sync_nxt;
  // clock and strobe pins get a third flop that only feeds the rising-edge detectors
  logic clk_d_r;
  logic clk_d_nxt;
  logic strb_d_r;
  logic strb_d_nxt;

  assign pin_raw = {in_frame, addr_inh2, addr_inh1, word_readout_strobe, dec_clk_in, pcm_in};

  always_comb begin
    meta_nxt = pin_raw;
    sync_nxt = meta_r;
    clk_d_nxt = sync_r[1];
    strb_d_nxt = sync_r[2];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
      clk_d_r <= 1'b0;
      strb_d_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      clk_d_r <= clk_d_nxt;
      strb_d_r <= strb_d_nxt;
    end
  end

  logic pcm_s;
  logic shift_en;
  logic load_en;
  logic inh1_s;
  logic inh2_s;
  logic frame_s;
  assign pcm_s = sync_r[0];
  // rising edges become one-cycle enables; a pulse shorter than two clk periods may be missed
  assign shift_en = sync_r[1] & ~clk_d_r;
  assign load_en = sync_r[2] & ~strb_d_r;
  assign inh1_s = sync_r[3];
  assign inh2_s = sync_r[4];
  assign frame_s = sync_r[5];

  // ----------------------------------------
  // serial and parallel word registers
  // ----------------------------------------
  logic [WORD_W-1:0] ser_r;
  logic [WORD_W-1:0] ser_nxt;
  logic [WORD_W-1:0] hold_r;
  logic [WORD_W-1:0] hold_nxt;
  logic normal_lsd;
  logic clear_lsd;

  // inhibit 1 blocks the normal lsd path, inhibit 2 low opens the clear path
  // both inhibits high is outside the timing contract; the held lsd then keeps its value
  assign normal_lsd = load_en & ~inh1_s;
  assign clear_lsd = load_en & ~inh2_s;

  always_comb begin
    ser_nxt = ser_r;
    hold_nxt = hold_r;
    // squelch: while out of frame the register sees no new bits
    if (shift_en && frame_s) begin
      ser_nxt = {ser_r[WORD_W-2:0], pcm_s};
    end
    if (load_en) begin
      hold_nxt[WORD_W-1:1] = ser_r[WORD_W-1:1];
    end
    if (normal_lsd) begin
      hold_nxt[LSD_POS] = ser_r[LSD_POS];
    end else if (clear_lsd) begin
      // clearing an already-zero stage is harmless
      hold_nxt[LSD_POS] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ser_r <= WORD_RST;
      hold_r <= WORD_RST;
    end else begin
      ser_r <= ser_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic atten;
  assign held_word = hold_r;
  // one xor decides the path, so both selects change on the same clk edge and never overlap
  assign atten = hold_r[MSD_POS] ^ hold_r[NMSD_POS];
  always_comb begin
    level_ctl.msd = hold_r[MSD_POS];
    level_ctl.msd_n = ~hold_r[MSD_POS];
    level_ctl.nmsd = hold_r[NMSD_POS];
    level_ctl.nmsd_n = ~hold_r[NMSD_POS];
    path_sel.atten_sel = atten;
    path_sel.direct_sel = ~atten;
  end
  // forwarded after synchronising so it rises with load_en, one clk before the held-word update
  assign modem_timing = sync_r[2];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // checks watch synchronised levels, so pin skew within one clk is invisible here

  a_shift_takes_bit: assert property (shift_en && frame_s |=> ser_r == {$past(ser_r[4:0]), $past(pcm_s)})
    else $error("serial shift wrong");
  a_squelch_holds: assert property (!frame_s |=> $stable(ser_r))
    else $error("shift while out of frame");
  a_shift_idle: assert property (!shift_en |=> $stable(ser_r))
    else $error("serial register moved without clock");
  a_shift_single: assert property (shift_en |=> !shift_en)
    else $error("shift enable longer than one cycle");
  a_frame_blocks: assert property (shift_en && !frame_s |=> ser_r == $past(ser_r))
    else $error("pcm passed while out of frame");

  // ----------------------------------------
  // held word and output checks
  // ----------------------------------------
  a_load_upper: assert property (load_en |=> hold_r[5:1] == $past(ser_r[5:1]))
    else $error("held word not loaded");
  a_hold_stable: assert property (!load_en |=> $stable(hold_r))
    else $error("held word changed without strobe");
  a_lsd_normal: assert property (load_en && !inh1_s |=> hold_r[0] == $past(ser_r[0]))
    else $error("lsd not transferred");
  a_lsd_blank: assert property (load_en && inh1_s && !inh2_s |=> hold_r[0] == 1'b0)
    else $error("address bit not blanked");
  a_level_pair: assert property (level_ctl.msd != level_ctl.msd_n && level_ctl.nmsd == hold_r[4])
    else $error("level controls wrong");
  a_path_one_hot: assert property (path_sel.atten_sel != path_sel.direct_sel)
    else $error("paths not exclusive");
  a_atten_range: assert property (path_sel.atten_sel == (hold_r >= 6'h10 && hold_r <= 6'h2f))
    else $error("attenuate range wrong");
  a_modem_follows: assert property ($rose(modem_timing) |-> load_en)
    else $error("modem timing not aligned");
  a_modem_quiet: assert property (!modem_timing |-> !load_en)
    else $error("load without modem timing");
  a_load_single: assert property (load_en |=> !load_en)
    else $error("load enable longer than one cycle");
  a_level_nmsd: assert property (level_ctl.nmsd != level_ctl.nmsd_n && level_ctl.msd == hold_r[5])
    else $error("next msd controls wrong");
  a_atten_digits: assert property (path_sel.atten_sel == (hold_r[5] != hold_r[4]))
    else $error("attenuate select not from top digits");
  a_direct_range: assert property (path_sel.direct_sel == (hold_r < 6'h10 || hold_r > 6'h2f))
    else $error("direct path range wrong");
  a_blank_stays_zero: assert property (load_en && inh1_s && !inh2_s && !hold_r[0] |=> !hold_r[0])
    else $error("zero address bit disturbed");
  a_lsd_held_both: assert property (load_en && inh1_s && inh2_s |=> hold_r[0] == $past(hold_r[0]))
    else $error("lsd moved with both inhibits high");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  c_frame_blank: cover property (load_en && inh1_s && !inh2_s && ser_r[0]);
  c_atten_word: cover property (load_en ##1 path_sel.atten_sel);
  c_squelch: cover property (shift_en && !frame_s);
  c_lsd_normal: cover property (load_en && !inh1_s && ser_r[0]);
  c_modem_pulse: cover property ($rose(modem_timing));

endmodule // pwd_core

/* File: dv/pwd_timing_model.sv */
// partner model: receive timing source for pcm, decoder clock, strobe, inhibits
// assumes clk at 25 MHz; pins change 1 ns after a rising edge
`timescale 1ns/1ps
module pwd_timing_model (
  // clock
  input wire logic clk,
  // pins toward the block
  output logic pcm_in,
  output logic dec_clk_in,
  output logic word_readout_strobe,
  output logic addr_inh1,
  output logic addr_inh2
);
  // ----------------------------------------
  // pin sequencing
  // ----------------------------------------
  initial begin
    pcm_in = 1'b0;
    dec_clk_in = 1'b0;
    word_readout_strobe = 1'b0;
    addr_inh1 = 1'b0;
    addr_inh2 = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // three-cycle phases keep each level clear of the two-flop sync
  task automatic send_word(input logic [5:0] w, input logic last);
    for (int i = 5; i >= 0; i--) begin
      pcm_in = w[i];
      step(3);
      dec_clk_in = 1'b1;
      step(3);
      dec_clk_in = 1'b0;
      step(1);
    end
    pcm_in = ~w[0];
    addr_inh1 = last;
    addr_inh2 = ~last;
    step(3);
    word_readout_strobe = 1'b1;
    step(3);
    word_readout_strobe = 1'b0;
    step(3);
    addr_inh1 = 1'b0;
    addr_inh2 = 1'b1;
  endtask
endmodule // pwd_timing_model

/* File: dv/tb_top.sv */
// testbench: scenario tasks against pwd_core with the timing model
// assumes one 25 MHz clock and no register bus
`timescale 1ns/1ps
module tb_top;
  import pwd_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic in_frame = 1'b1;
  logic pcm_in, dec_clk_in, word_readout_strobe, addr_inh1, addr_inh2, modem_timing;
  logic [WORD_W-1:0] held_word;
  pwd_level_t level_ctl;
  pwd_path_t path_sel;
  int num_errors = 0;
  int cmp_count = 0;
  logic [5:0] lv [8] = '{6'h00, 6'h0F, 6'h10, 6'h2F, 6'h30, 6'h3F, 6'h2A, 6'h15};
  always #20 clk = ~clk;
  pwd_timing_model pwd_timing_model_inst (.clk(clk), .pcm_in(pcm_in), .dec_clk_in(dec_clk_in),
    .word_readout_strobe(word_readout_strobe), .addr_inh1(addr_inh1), .addr_inh2(addr_inh2));
  pwd_core pwd_core_inst (.clk(clk), .rst_b(rst_b), .pcm_in(pcm_in), .dec_clk_in(dec_clk_in),
    .word_readout_strobe(word_readout_strobe), .addr_inh1(addr_inh1), .addr_inh2(addr_inh2),
    .in_frame(in_frame), .held_word(held_word), .level_ctl(level_ctl), .path_sel(path_sel),
    .modem_timing(modem_timing));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [5:0] seen, input logic [5:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // path expectation comes from the level range, not from the digit pattern
  task automatic word_is(input logic [5:0] w, input logic last, input logic [5:0] exp);
    logic att;
    pwd_timing_model_inst.send_word(w, last);
    att = (exp >= 6'h10) && (exp <= 6'h2F);
    check("held_word", held_word, exp);
    check("level_ctl", {2'h0, level_ctl}, {2'h0, exp[5], ~exp[5], exp[4], ~exp[4]});
    check("path_sel", {4'h0, path_sel}, {4'h0, att, ~att});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_levels();
    foreach (lv[i]) word_is(lv[i], 1'b0, lv[i]);
    $display("test levels done");
  endtask
  task automatic t_blank();
    word_is(6'h3F, 1'b1, 6'h3E);
    word_is(6'h2A, 1'b1, 6'h2A);
    word_is(6'h01, 1'b0, 6'h01);
    $display("test blank done");
  endtask
  task automatic t_squelch();
    in_frame = 1'b0;
    pwd_timing_model_inst.step(3);
    word_is(6'h15, 1'b0, 6'h01);
    in_frame = 1'b1;
    pwd_timing_model_inst.step(3);
    word_is(6'h15, 1'b0, 6'h15);
    $display("test squelch done");
  endtask
  task automatic t_modem();
    int n;
    fork
      pwd_timing_model_inst.send_word(6'h0C, 1'b0);
      begin
        n = 0;
        while (word_readout_strobe !== 1'b1 && n < 200) begin
          @(posedge clk);
          n++;
        end
        if (n >= 200) report_and_stop();
        @(posedge clk);
        #2;
        check("modem_timing high", {5'h00, modem_timing}, 6'h01);
      end
    join
    check("modem_timing low", {5'h00, modem_timing}, 6'h00);
    $display("test modem done");
  endtask
  initial begin
    @(posedge clk);
    #1;
    check("held_word rst", held_word, 6'h00);
    check("level_ctl rst", {2'h0, level_ctl}, 6'h05);
    check("path_sel rst", {4'h0, path_sel}, 6'h01);
    @(posedge clk);
    #1;
    rst_b = 1'b1;
    pwd_timing_model_inst.step(2);
    t_levels();
    t_blank();
    t_squelch();
    t_modem();
    report_and_stop();
  end
endmodule // tb_top
